// ### eocc_cfg.svh
// Purpose: Constants for the external oscillator clock control block
// Assumes: Included by its bare name wherever a constant is needed
// Notes: Definitions only
`ifndef EOCC_CFG_SVH
`define EOCC_CFG_SVH

// Mode input encoding
`define EOCC_MODE_W 3
`define EOCC_MODE_OFF 3'h0
`define EOCC_MODE_CMOS 3'h2
`define EOCC_MODE_RC 3'h4
`define EOCC_MODE_CAP 3'h5
`define EOCC_MODE_XTAL 3'h6

// Frequency control field
`define EOCC_FCN_W 3
`define EOCC_FCN_RST 3'h0

// Port 0 bit positions, large and small package
`define EOCC_PORT_W 8
`define EOCC_LG_PIN_IN 3'h6
`define EOCC_LG_PIN_OUT 3'h7
`define EOCC_SM_PIN_IN 3'h2
`define EOCC_SM_PIN_OUT 3'h3

// Divide ratio of the peripheral clock
`define EOCC_DIV_RATIO 8
`define EOCC_DIV_CNT_W 2
`define EOCC_DIV_HALF 2'h3

// Amplitude qualification
`define EOCC_QUAL_W 4
`define EOCC_QUAL_CYCLES 4'h8

// Software wait before polling the valid flag
`define EOCC_START_WAIT_US 1000
`define EOCC_CLK_MHZ 10
`define EOCC_START_WAIT_CYC (`EOCC_START_WAIT_US * `EOCC_CLK_MHZ)

`endif

// ### eocc_pkg.sv
// Purpose: Types for the external oscillator clock control block
// Assumes: eocc_cfg.svh holds every number except the enum encodings set here
// Notes: Types only
package eocc_pkg;
   typedef enum logic [2:0] {
      EOCC_OFF = 3'b000,
      EOCC_CMOS = 3'b001,
      EOCC_RC = 3'b010,
      EOCC_CAP = 3'b011,
      EOCC_XTAL = 3'b100
   } eocc_mode_t;

   typedef enum logic [1:0] {
      EOCC_V_DIS = 2'b00,
      EOCC_V_SETTLE = 2'b01,
      EOCC_V_VALID = 2'b10
   } eocc_vstate_t;
endpackage : eocc_pkg

// ### eocc_div_if.sv
// Purpose: Link between the top and the divide-by-eight synchroniser
// Assumes: Single system clock
// Notes: Top drives run, divider drives its outputs
`timescale 1ns/1ps
interface eocc_div_if;
   logic run;
   logic osc_clk;
   logic div_lvl;
   logic div_tick;

   modport top (output run, output osc_clk, input div_lvl, input div_tick);
   modport div (input run, input osc_clk, output div_lvl, output div_tick);
endinterface : eocc_div_if

// ### eocc_div8.sv
// Purpose: Resynchronise the external clock and divide it by eight
// Assumes: External frequency at most a quarter of the system clock frequency
// Notes: Edge quantised to one system clock, jitter up to one cycle
`timescale 1ns/1ps
`include "eocc_cfg.svh"
module eocc_div8
   import eocc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   eocc_div_if.div dv
);
   logic s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
   logic f_q, f_d;
   logic [`EOCC_DIV_CNT_W-1:0] cnt_q, cnt_d;
   logic lvl_q, lvl_d, tick_q, tick_d;

   always_comb begin
      s1_d = dv.osc_clk;
      s2_d = s1_q;
      s3_d = s2_q;
      // Level accepted once the two later stages agree
      f_d = (s2_q == s3_q) ? s3_q : f_q;
      cnt_d = cnt_q;
      lvl_d = lvl_q;
      tick_d = 1'b0;
      if (!dv.run) begin
         cnt_d = '0;
         lvl_d = 1'b0;
      end else if (f_d && !f_q) begin
         cnt_d = cnt_q + 1'b1;
         if (cnt_q == `EOCC_DIV_HALF) begin
            lvl_d = !lvl_q;
            tick_d = lvl_q;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         f_q <= 1'b0;
         cnt_q <= '0;
         lvl_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         f_q <= f_d;
         cnt_q <= cnt_d;
         lvl_q <= lvl_d;
         tick_q <= tick_d;
      end
   end

   assign dv.div_lvl = lvl_q;
   assign dv.div_tick = tick_q;
endmodule : eocc_div8

// ### eocc_top.sv
// Purpose: Digital control of the external oscillator drive circuit
// Assumes: One 10 MHz system clock, synchronous active-high reset
// Notes: Control bits arrive as plain inputs, no software registers
//
// Function
// - Crystal mode claims both oscillator port bits for the selected package.
// - Capacitor, RC and CMOS modes claim only the oscillator output bit.
// - External clock divided by eight is offered to timers and counter array.
// - Divided clock is resynchronised to system clock, jitter up to one cycle.
`timescale 1ns/1ps
`include "eocc_cfg.svh"
module eocc_top
   import eocc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [`EOCC_MODE_W-1:0] osc_mode_i,
   input wire logic [`EOCC_FCN_W-1:0] ext_freq_control_i,
   input wire logic small_pkg_i,
   input wire logic sysclk_is_ext_i,
   input wire logic ext_osc_clk_i,
   input wire logic amp_ok_i,
   output logic [`EOCC_PORT_W-1:0] pin_claim_o,
   output logic [`EOCC_PORT_W-1:0] pin_dig_in_o,
   output logic [`EOCC_FCN_W-1:0] drive_fcn_o,
   output logic xtal_drive_en_o,
   output logic rc_drive_en_o,
   output logic cap_drive_en_o,
   output logic cmos_in_en_o,
   output logic ext_div8_clk_o,
   output logic ext_div8_tick_o,
   output logic crystal_valid_flag_o
);
   ////////////////////////////////////////////////////////////////////////
   // Mode decode

   function automatic eocc_mode_t dec_mode(
      input logic [`EOCC_MODE_W-1:0] m
   );
      eocc_mode_t r;
      case (m)
         `EOCC_MODE_CMOS: r = EOCC_CMOS;
         `EOCC_MODE_RC: r = EOCC_RC;
         `EOCC_MODE_CAP: r = EOCC_CAP;
         `EOCC_MODE_XTAL: r = EOCC_XTAL;
         default: r = EOCC_OFF;
      endcase
      return r;
   endfunction : dec_mode

   function automatic logic [`EOCC_PORT_W-1:0] bit_mask(
      input logic [2:0] pos
   );
      logic [`EOCC_PORT_W-1:0] r;
      r = '0;
      r[pos] = 1'b1;
      return r;
   endfunction : bit_mask

   eocc_mode_t mode_q, mode_d;
   eocc_mode_t mode_now;

   always_comb begin
      mode_now = dec_mode(osc_mode_i);
      mode_d = mode_now;
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin ownership and drive enables

   logic [`EOCC_PORT_W-1:0] claim_q, claim_d, dig_q, dig_d;
   logic [`EOCC_FCN_W-1:0] fcn_q, fcn_d;
   logic xen_q, xen_d, ren_q, ren_d, cen_q, cen_d, men_q, men_d;
   logic [`EOCC_PORT_W-1:0] in_mask, out_mask;

   always_comb begin
      in_mask = small_pkg_i ? bit_mask(`EOCC_SM_PIN_IN)
                            : bit_mask(`EOCC_LG_PIN_IN);
      out_mask = small_pkg_i ? bit_mask(`EOCC_SM_PIN_OUT)
                             : bit_mask(`EOCC_LG_PIN_OUT);
      claim_d = '0;
      dig_d = '0;
      xen_d = 1'b0;
      ren_d = 1'b0;
      cen_d = 1'b0;
      men_d = 1'b0;
      // Frequency setting only reaches the drive while it is enabled
      fcn_d = `EOCC_FCN_RST;
      case (mode_now)
         EOCC_XTAL: begin
            claim_d = in_mask | out_mask;
            dig_d = in_mask | out_mask;
            xen_d = 1'b1;
            fcn_d = ext_freq_control_i;
         end
         EOCC_RC: begin
            claim_d = out_mask;
            dig_d = out_mask;
            ren_d = 1'b1;
            fcn_d = ext_freq_control_i;
         end
         EOCC_CAP: begin
            claim_d = out_mask;
            dig_d = out_mask;
            cen_d = 1'b1;
            fcn_d = ext_freq_control_i;
         end
         EOCC_CMOS: begin
            // Driven clock, no digital-input hint needed
            claim_d = out_mask;
            men_d = 1'b1;
         end
         default: begin
            claim_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= EOCC_OFF;
         claim_q <= '0;
         dig_q <= '0;
         fcn_q <= `EOCC_FCN_RST;
         xen_q <= 1'b0;
         ren_q <= 1'b0;
         cen_q <= 1'b0;
         men_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         claim_q <= claim_d;
         dig_q <= dig_d;
         fcn_q <= fcn_d;
         xen_q <= xen_d;
         ren_q <= ren_d;
         cen_q <= cen_d;
         men_q <= men_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Divided clock for timers and counter array

   eocc_div_if dif ();
   logic dclk_q, dclk_d, dtick_q, dtick_d;

   // Divider held idle with the oscillator off, so it restarts in phase
   assign dif.run = (mode_q != EOCC_OFF);
   assign dif.osc_clk = ext_osc_clk_i;

   eocc_div8 u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .dv(dif.div)
   );

   always_comb begin
      dclk_d = dif.div_lvl;
      dtick_d = dif.div_tick;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dclk_q <= 1'b0;
         dtick_q <= 1'b0;
      end else begin
         dclk_q <= dclk_d;
         dtick_q <= dtick_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Crystal valid flag

   logic a1_q, a2_q, a3_q, af_q;
   logic a1_d, a2_d, a3_d, af_d;
   eocc_vstate_t vst_q, vst_d;
   logic [`EOCC_QUAL_W-1:0] qcnt_q, qcnt_d;
   logic valid_q, valid_d;

   always_comb begin
      a1_d = amp_ok_i;
      a2_d = a1_q;
      a3_d = a2_q;
      af_d = (a2_q == a3_q) ? a3_q : af_q;
   end

   // Amplitude must hold steadily before the flag is raised,
   // so a brief detector glitch at start-up cannot report valid
   always_comb begin
      vst_d = vst_q;
      qcnt_d = qcnt_q;
      valid_d = 1'b0;
      case (vst_q)
         EOCC_V_DIS: begin
            qcnt_d = '0;
            if (mode_q == EOCC_XTAL)
               vst_d = EOCC_V_SETTLE;
         end
         EOCC_V_SETTLE: begin
            if (!af_q)
               qcnt_d = '0;
            else if (qcnt_q != `EOCC_QUAL_CYCLES)
               qcnt_d = qcnt_q + 1'b1;
            if (af_q && qcnt_q == `EOCC_QUAL_CYCLES) begin
               vst_d = EOCC_V_VALID;
               valid_d = 1'b1;
            end
         end
         EOCC_V_VALID: begin
            valid_d = 1'b1;
            if (!af_q) begin
               vst_d = EOCC_V_SETTLE;
               qcnt_d = '0;
               valid_d = 1'b0;
            end
         end
         default: begin
            vst_d = EOCC_V_DIS;
            qcnt_d = '0;
         end
      endcase
      // Leaving crystal mode clears at once
      if (mode_q != EOCC_XTAL) begin
         vst_d = EOCC_V_DIS;
         qcnt_d = '0;
         valid_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         a1_q <= 1'b0;
         a2_q <= 1'b0;
         a3_q <= 1'b0;
         af_q <= 1'b0;
         vst_q <= EOCC_V_DIS;
         qcnt_q <= '0;
         valid_q <= 1'b0;
      end else begin
         a1_q <= a1_d;
         a2_q <= a2_d;
         a3_q <= a3_d;
         af_q <= af_d;
         vst_q <= vst_d;
         qcnt_q <= qcnt_d;
         valid_q <= valid_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops

   assign pin_claim_o = claim_q;
   assign pin_dig_in_o = dig_q;
   assign drive_fcn_o = fcn_q;
   assign xtal_drive_en_o = xen_q;
   assign rc_drive_en_o = ren_q;
   assign cap_drive_en_o = cen_q;
   assign cmos_in_en_o = men_q;
   assign ext_div8_clk_o = dclk_q;
   assign ext_div8_tick_o = dtick_q;
   assign crystal_valid_flag_o = valid_q;

   // sysclk_is_ext_i is informational: the resynchronised divided clock
   // is used either way, which is harmless when ext is the system clock
   logic unused_sel;
   assign unused_sel = sysclk_is_ext_i;
endmodule : eocc_top

// ### eocc_top_chk.sv
// Purpose: Port assertions for eocc_top
// Assumes: Mode codes from eocc_cfg.svh
// Notes: Bound to every eocc_top instance
`timescale 1ns/1ps
`include "eocc_cfg.svh"
module eocc_top_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [`EOCC_MODE_W-1:0] osc_mode_i,
   input wire logic [`EOCC_FCN_W-1:0] ext_freq_control_i,
   input wire logic small_pkg_i,
   input wire logic amp_ok_i,
   input wire logic [`EOCC_PORT_W-1:0] pin_claim_o,
   input wire logic [`EOCC_FCN_W-1:0] drive_fcn_o,
   input wire logic ext_div8_clk_o,
   input wire logic ext_div8_tick_o,
   input wire logic crystal_valid_flag_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_xtal_lg;
      osc_mode_i == `EOCC_MODE_XTAL && !small_pkg_i |=> pin_claim_o == 8'hC0;
   endproperty
   a_xtal_lg: assert property (p_xtal_lg) else $error("xtal large");
   property p_xtal_sm;
      osc_mode_i == `EOCC_MODE_XTAL && small_pkg_i |=> pin_claim_o == 8'h0C;
   endproperty
   a_xtal_sm: assert property (p_xtal_sm) else $error("xtal small");
   property p_one_pin;
      osc_mode_i inside {`EOCC_MODE_CMOS, `EOCC_MODE_RC, `EOCC_MODE_CAP}
      |=> pin_claim_o == ($past(small_pkg_i) ? 8'h08 : 8'h80);
   endproperty
   a_one_pin: assert property (p_one_pin) else $error("one pin");
   property p_off;
      !(osc_mode_i inside {3'h2, 3'h4, 3'h5, 3'h6})
      |=> pin_claim_o == 8'h00 && drive_fcn_o == 3'h0;
   endproperty
   a_off: assert property (p_off) else $error("off claims");
   property p_fcn;
      osc_mode_i == `EOCC_MODE_XTAL |=> drive_fcn_o == $past(ext_freq_control_i);
   endproperty
   a_fcn: assert property (p_fcn) else $error("fcn pass");
   property p_vld_mode;
      // Mode passes its own register first, so the flag clears a cycle later
      osc_mode_i != `EOCC_MODE_XTAL |=> ##1 !crystal_valid_flag_o;
   endproperty
   a_vld_mode: assert property (p_vld_mode) else $error("vld mode");
   property p_vld_amp;
      !amp_ok_i [*8] |=> !crystal_valid_flag_o;
   endproperty
   a_vld_amp: assert property (p_vld_amp) else $error("vld amp");
   property p_tick;
      ext_div8_tick_o |-> $fell(ext_div8_clk_o) ##1 !ext_div8_tick_o;
   endproperty
   a_tick: assert property (p_tick) else $error("tick");
   property p_div_hi;
      $rose(ext_div8_clk_o) |=> ext_div8_clk_o [*6];
   endproperty
   a_div_hi: assert property (p_div_hi) else $error("div high");
endmodule : eocc_top_chk
bind eocc_top eocc_top_chk u_eocc_top_chk (.clk_i(clk_i), .rst_i(rst_i),
   .osc_mode_i(osc_mode_i), .ext_freq_control_i(ext_freq_control_i),
   .small_pkg_i(small_pkg_i), .amp_ok_i(amp_ok_i), .pin_claim_o(pin_claim_o),
   .drive_fcn_o(drive_fcn_o), .ext_div8_clk_o(ext_div8_clk_o),
   .ext_div8_tick_o(ext_div8_tick_o),
   .crystal_valid_flag_o(crystal_valid_flag_o));

// ### eocc_osc_model.sv
// Purpose: External oscillator and amplitude detector stand-in
// Assumes: Clock stands at 0 while disabled
// Notes: fault_i pulls amplitude low to mimic a lost crystal
`timescale 1ns/1ps
module eocc_osc_model #(
   parameter int HALF_NS = 350,
   parameter int SETTLE_NS = 5000
) (
   input wire logic en_i,
   input wire logic fault_i,
   output logic osc_clk_o,
   output logic amp_ok_o
);
   logic amp_q = 1'b0;
   // Well below half the system clock, so every level is sampled
   always begin
      if (en_i) begin
         #HALF_NS osc_clk_o = ~osc_clk_o;
      end else begin
         osc_clk_o = 1'b0;
         @(en_i);
      end
   end
   always @(en_i) begin
      amp_q = 1'b0;
      if (en_i) #SETTLE_NS amp_q = en_i;
   end
   assign amp_ok_o = amp_q & ~fault_i;
endmodule : eocc_osc_model

// ### eocc_top_tb.sv
// Purpose: Self-checking bench for eocc_top
// Assumes: 10 MHz system clock, 700 ns external period
// Notes: Inputs change on rising edges, outputs read on falling edges
`timescale 1ns/1ps
`include "eocc_cfg.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
   bad_count++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module eocc_top_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [`EOCC_MODE_W-1:0] osc_mode_i = 3'h0;
   logic [`EOCC_FCN_W-1:0] fcn = 3'h0;
   logic small_pkg_i = 1'b0;
   logic osc_en = 1'b0;
   logic fault = 1'b0;
   wire ext_clk;
   wire amp_ok;
   logic [7:0] claim, dig;
   logic [2:0] fcn_o;
   logic xen, ren, cen, men, dclk, tick, vld;
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int ext_cnt = 0;
   always #50 clk_i = ~clk_i;
   always @(posedge ext_clk) ext_cnt++;
   eocc_osc_model u_eocc_osc_model (.en_i(osc_en), .fault_i(fault),
      .osc_clk_o(ext_clk), .amp_ok_o(amp_ok));
   eocc_top u_eocc_top (.clk_i(clk_i), .rst_i(rst_i), .osc_mode_i(osc_mode_i),
      .ext_freq_control_i(fcn), .small_pkg_i(small_pkg_i),
      .sysclk_is_ext_i(1'b0), .ext_osc_clk_i(ext_clk), .amp_ok_i(amp_ok),
      .pin_claim_o(claim), .pin_dig_in_o(dig), .drive_fcn_o(fcn_o),
      .xtal_drive_en_o(xen), .rc_drive_en_o(ren), .cap_drive_en_o(cen),
      .cmos_in_en_o(men), .ext_div8_clk_o(dclk), .ext_div8_tick_o(tick),
      .crystal_valid_flag_o(vld));
   task automatic stop_test();
      if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic t_pins();
      logic [7:0] ec;
      logic [3:0] ee;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk_i);
         osc_mode_i <= i[2:0];
         small_pkg_i <= i[3];
         fcn <= ~i[2:0];
         ee = (i[2:0] == 3'h6) ? 4'h8 : (i[2:0] == 3'h4) ? 4'h4 :
              (i[2:0] == 3'h5) ? 4'h2 : (i[2:0] == 3'h2) ? 4'h1 : 4'h0;
         ec = (ee == 4'h8) ? (i[3] ? 8'h0C : 8'hC0) :
              (ee != 4'h0) ? (i[3] ? 8'h08 : 8'h80) : 8'h00;
         @(posedge clk_i);
         @(negedge clk_i);
         // Software hands the claim mask to the crossbar as its skip mask
         `CHK("claim", ec, claim)
         `CHK("dig_in", (ee > 4'h1) ? ec : 8'h00, dig)
         `CHK("fcn", (ee > 4'h1) ? ~i[2:0] : 3'h0, fcn_o)
         `CHK("enables", ee, {xen, ren, cen, men})
      end
   endtask : t_pins
   task automatic t_valid();
      int n;
      @(posedge clk_i);
      small_pkg_i <= 1'b0;
      osc_mode_i <= `EOCC_MODE_XTAL;
      osc_en <= 1'b1;
      repeat (3) @(negedge clk_i);
      `CHK("vld_early", 1'b0, vld)
      repeat (`EOCC_START_WAIT_CYC) @(negedge clk_i);
      n = 0;
      while (vld !== 1'b1 && n < 100) begin
         @(negedge clk_i);
         n++;
      end
      `CHK("vld_set", 1'b1, vld)
      @(posedge clk_i);
      fault <= 1'b1;
      repeat (12) @(negedge clk_i);
      `CHK("vld_drop", 1'b0, vld)
      @(posedge clk_i);
      fault <= 1'b0;
      osc_mode_i <= `EOCC_MODE_RC;
      repeat (30) @(negedge clk_i);
      `CHK("vld_rc", 1'b0, vld)
   endtask : t_valid
   // Tick spacing of 8 external periods, 56 system cycles nominal
   task automatic t_div();
      int n, e0;
      n = 0;
      while (tick !== 1'b1 && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      e0 = ext_cnt;
      @(negedge clk_i);
      n = 1;
      while (tick !== 1'b1 && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      `CHK("ext_edges", 8, ext_cnt - e0)
      `CHK("tick_gap", 1'b1, n >= 55 && n <= 57)
      // Stop in the high phase, else the clear could never show
      n = 0;
      while (dclk !== 1'b1 && n < 100) begin
         @(negedge clk_i);
         n++;
      end
      repeat (10) @(negedge clk_i);
      `CHK("div_hi", 1'b1, dclk)
      @(posedge clk_i);
      osc_mode_i <= `EOCC_MODE_OFF;
      osc_en <= 1'b0;
      repeat (8) @(negedge clk_i);
      `CHK("div_off", 1'b0, dclk)
   endtask : t_div
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_pins();
      t_valid();
      t_div();
      stop_test();
   end
endmodule : eocc_top_tb
